// >>> logic/voltage_monitor_pkg.sv
// constants of the scanning voltage monitor: offsets, fields, resets, timing
`default_nettype none
package voltage_monitor_pkg;
  // ==========================================================
  // register indices (byte address = 4 * index)
  localparam logic [7:0] EVT_STAT0 = 8'h00;
  localparam logic [7:0] EVT_STAT1 = 8'h01;
  localparam logic [7:0] SMI_EN0 = 8'h02;
  localparam logic [7:0] SMI_EN1 = 8'h03;
  localparam logic [7:0] IRQ_EN0 = 8'h04;
  localparam logic [7:0] IRQ_EN1 = 8'h05;
  localparam logic [7:0] CONV_RATE = 8'h07;
  localparam logic [7:0] MON_CFG = 8'h08;
  localparam logic [7:0] BANK_SEL = 8'h09;
  localparam logic [7:0] CH_CFG = 8'h0a;
  localparam logic [7:0] CH_RESULT = 8'h0b;
  localparam logic [7:0] CH_HIGH = 8'h0c;
  localparam logic [7:0] CH_LOW = 8'h0d;
  // ==========================================================
  // configuration port
  localparam logic [7:0] PORT_BASE0 = 8'h2e;
  localparam logic [7:0] PORT_BASE1 = 8'h4e;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] LDN_MONITOR = 8'h0d;
  // ==========================================================
  // field positions
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_HIGH_BIT = 1;
  localparam int CFG_LOW_BIT = 2;
  localparam int CFG_ALARM_BIT = 4;
  localparam int CFG_DONE_BIT = 7;
  localparam int MON_STANDBY_BIT = 0;
  localparam int RATE_GAP_LSB = 3;
  // ==========================================================
  // reset values
  localparam logic [7:0] MON_CFG_RST = 8'h03;
  localparam logic [7:0] HIGH_RST = 8'hff;
  localparam logic [7:0] LOW_RST = 8'h00;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  // ==========================================================
  // channels and timing
  localparam int NUM_CHANNELS = 11;
  localparam int CH_STANDBY = 7;
  localparam int CH_MAIN = 8;
  localparam int CH_ANALOG = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_STEP_NS = 40000;
  localparam int SETTLE_STEP_CYC = (SETTLE_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// >>> logic/voltage_level_monitor.sv
// scanning voltage monitor: apb registers, config port, scan sequencer, alarms
//
// The address map and the APB register port were decided locally.
`default_nettype none
// How it works
// - index/data port pair sits at 2Eh or 4Eh by the strap caught on the first clock after reset release.
// - monitor answers as logical device 0Dh through the index/data port.
// - once enabled, all enabled channels are converted in turn, forever.
// - no conversion starts or completes while power-loss sleep is high.
// - all register state sits on standby power; only its reset clears it.
// - each 8-bit result lands in the result register of the converted channel.
// - results outside the high or low limit set the exceeded flags.
// - exceeded flags stay set until software writes one to clear them.
// - a channel's alarm status bit sets together with its exceeded flag.
// - active-low smi asserts while any status bit and smi enable meet.
// - irq asserts while any status bit and irq enable meet.
// - eleven channels: seven external, standby, main, battery, analog.
// - standby, main and analog supplies are channels 7, 8 and 10.
// - those three channels read halved; software scales over 128.
// - bank select at 09h picks the visible channel, resets to zero.
// - config bit 7 flags a completed conversion; result sits at 0Bh.
// - limits compare only with config bit 4 set; bits 1, 2 report.
module voltage_level_monitor #(
  parameter int NUM_CH = voltage_monitor_pkg::NUM_CHANNELS,
  parameter int SETTLE_STEP_CYCLES = voltage_monitor_pkg::SETTLE_STEP_CYC,
  localparam int CH_W = $clog2(NUM_CH)
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // board pins
  input wire logic configPortSelectStrap,
  input wire logic powerLossSleep,
  // converter core
  output logic adcStart,
  output logic [CH_W-1:0] adcChannel,
  input wire logic adcDone,
  input wire logic [7:0] adcResult,
  // interrupts
  output logic smiN,
  output logic irq
);
  typedef enum logic [1:0] {S_PICK, S_CONVERT, S_SETTLE} seq_t;

  // ==========================================================
  // elaboration checks
  if (NUM_CH < 11 || NUM_CH > 16) begin : g_bad_ch
    $error("NUM_CH must be 11 to 16");
  end
  if (SETTLE_STEP_CYCLES < 1 || SETTLE_STEP_CYCLES > 8191) begin : g_bad_step
    $error("SETTLE_STEP_CYCLES out of range");
  end

  logic strapQ, strapTakenQ, ackQ, errQ, activeQ;
  logic [31:0] prdataQ;
  logic [7:0] idxQ, ldnQ, rateQ, monCfgQ, bankQ;
  logic [NUM_CH-1:0] evtStatQ, smiEnQ, irqEnQ;
  logic [7:0] cfgQ [NUM_CH];
  logic [7:0] resQ [NUM_CH];
  logic [7:0] hiQ [NUM_CH];
  logic [7:0] loQ [NUM_CH];
  seq_t stateQ;
  logic [CH_W-1:0] chQ;
  logic [15:0] settleQ;

  // ==========================================================
  // strap capture: a clocked load after release, never in reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strapQ <= 1'b0;
      strapTakenQ <= 1'b0;
    end else if (!strapTakenQ) begin
      strapQ <= configPortSelectStrap;
      strapTakenQ <= 1'b1;
    end
  end

  // ==========================================================
  // address decode
  logic [7:0] regIdx, portBase, rdMux, cfgData;
  logic decErr, bankOk, commit;
  logic [CH_W-1:0] bankIdx;
  logic [15:0] wrPlaced;
  assign regIdx = paddr[9:2];
  assign portBase = strapQ ? voltage_monitor_pkg::PORT_BASE1
                           : voltage_monitor_pkg::PORT_BASE0;
  assign bankOk = bankQ < 8'(NUM_CH);
  assign bankIdx = bankQ[CH_W-1:0];
  // odd indices of the split pairs hold the upper channels
  assign wrPlaced = regIdx[0] ? {pwdata[7:0], 8'h00} : {8'h00, pwdata[7:0]};
  assign commit = psel & penable & pwrite & ackQ & ~errQ;

  // data port readback: ldn always, activate only for our device
  always_comb begin
    cfgData = 8'h00;
    if (idxQ == voltage_monitor_pkg::IDX_LDN) begin
      cfgData = ldnQ;
    end else if (idxQ == voltage_monitor_pkg::IDX_ACTIVATE &&
                 ldnQ == voltage_monitor_pkg::LDN_MONITOR) begin
      cfgData = {7'h00, activeQ};
    end
  end

  // read mux and error decode; monitor space is dark until activated
  always_comb begin
    rdMux = 8'h00;
    decErr = 1'b0;
    if (paddr[11:10] != 2'b00) begin
      decErr = 1'b1;
    end else if (regIdx == portBase) begin
      rdMux = idxQ;
    end else if (regIdx == portBase + 8'h01) begin
      rdMux = cfgData;
    end else if (!activeQ) begin
      decErr = 1'b1;
    end else begin
      case (regIdx)
        voltage_monitor_pkg::EVT_STAT0: rdMux = 8'(evtStatQ);
        voltage_monitor_pkg::EVT_STAT1: rdMux = 8'(evtStatQ >> 8);
        voltage_monitor_pkg::SMI_EN0: rdMux = 8'(smiEnQ);
        voltage_monitor_pkg::SMI_EN1: rdMux = 8'(smiEnQ >> 8);
        voltage_monitor_pkg::IRQ_EN0: rdMux = 8'(irqEnQ);
        voltage_monitor_pkg::IRQ_EN1: rdMux = 8'(irqEnQ >> 8);
        voltage_monitor_pkg::CONV_RATE: rdMux = rateQ;
        voltage_monitor_pkg::MON_CFG: rdMux = monCfgQ;
        voltage_monitor_pkg::BANK_SEL: rdMux = bankQ;
        voltage_monitor_pkg::CH_CFG: rdMux = bankOk ? cfgQ[bankIdx] : 8'h00;
        voltage_monitor_pkg::CH_RESULT: rdMux = bankOk ? resQ[bankIdx] : 8'h00;
        voltage_monitor_pkg::CH_HIGH: rdMux = bankOk ? hiQ[bankIdx] : 8'h00;
        voltage_monitor_pkg::CH_LOW: rdMux = bankOk ? loQ[bankIdx] : 8'h00;
        default: decErr = 1'b1;
      endcase
    end
  end

  // ==========================================================
  // apb answer: one wait state so read data comes from a flop
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ackQ <= 1'b0;
      errQ <= 1'b0;
      prdataQ <= 32'h0000_0000;
    end else if (psel && penable && !ackQ) begin
      ackQ <= 1'b1;
      errQ <= decErr;
      prdataQ <= {24'h00_0000, pwrite ? 8'h00 : rdMux};
    end else begin
      ackQ <= 1'b0;
    end
  end
  assign pready = psel & penable & ackQ;
  assign pslverr = pready & errQ;
  assign prdata = prdataQ;

  // ==========================================================
  // index/data port, logical device and activation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idxQ <= 8'h00;
      ldnQ <= 8'h00;
      activeQ <= 1'b0;
    end else if (commit && regIdx == portBase) begin
      idxQ <= pwdata[7:0];
    end else if (commit && regIdx == portBase + 8'h01) begin
      if (idxQ == voltage_monitor_pkg::IDX_LDN) begin
        ldnQ <= pwdata[7:0];
      end else if (idxQ == voltage_monitor_pkg::IDX_ACTIVATE &&
                   ldnQ == voltage_monitor_pkg::LDN_MONITOR) begin
        activeQ <= pwdata[0];
      end
    end
  end

  // ==========================================================
  // global monitor registers; reset only by the standby-domain reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smiEnQ <= '0;
      irqEnQ <= '0;
      rateQ <= voltage_monitor_pkg::RATE_RST;
      monCfgQ <= voltage_monitor_pkg::MON_CFG_RST;
      bankQ <= voltage_monitor_pkg::BANK_RST;
    end else if (commit) begin
      case (regIdx)
        voltage_monitor_pkg::SMI_EN0,
        voltage_monitor_pkg::SMI_EN1: smiEnQ <= NUM_CH'(regIdx[0] ?
          (smiEnQ & 16'(8'hff)) | wrPlaced : (smiEnQ & ~16'(8'hff)) | wrPlaced);
        voltage_monitor_pkg::IRQ_EN0,
        voltage_monitor_pkg::IRQ_EN1: irqEnQ <= NUM_CH'(regIdx[0] ?
          (irqEnQ & 16'(8'hff)) | wrPlaced : (irqEnQ & ~16'(8'hff)) | wrPlaced);
        voltage_monitor_pkg::CONV_RATE: rateQ <= pwdata[7:0];
        voltage_monitor_pkg::MON_CFG: monCfgQ <= pwdata[7:0];
        voltage_monitor_pkg::BANK_SEL: bankQ <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // scan sequencer
  logic running, chEnabled, convDone, lastCh;
  logic [CH_W-1:0] nextCh;
  logic [15:0] settleLoad;
  assign running = activeQ & ~monCfgQ[voltage_monitor_pkg::MON_STANDBY_BIT]
                 & ~powerLossSleep;
  assign chEnabled = cfgQ[chQ][voltage_monitor_pkg::CFG_EN_BIT];
  assign lastCh = chQ == CH_W'(NUM_CH - 1);
  assign nextCh = lastCh ? '0 : chQ + CH_W'(1);
  assign adcStart = stateQ == S_PICK && running && chEnabled;
  assign adcChannel = chQ;
  // a sleep entry mid-conversion discards the result
  assign convDone = stateQ == S_CONVERT && adcDone && !powerLossSleep;
  assign settleLoad = 16'((int'(rateQ[5:3]) + 1) * SETTLE_STEP_CYCLES);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= S_PICK;
      chQ <= '0;
      settleQ <= 16'h0000;
    end else begin
      unique case (stateQ)
        S_PICK: begin
          if (adcStart) begin
            stateQ <= S_CONVERT;
          end else if (running) begin
            chQ <= nextCh;
          end
        end
        S_CONVERT: begin
          if (powerLossSleep) begin
            stateQ <= S_PICK;
          end else if (adcDone) begin
            stateQ <= S_SETTLE;
            settleQ <= settleLoad;
          end
        end
        S_SETTLE: begin
          // input settling gap before the mux moves on
          if (settleQ <= 16'h0001) begin
            stateQ <= S_PICK;
            chQ <= nextCh;
          end else begin
            settleQ <= settleQ - 16'h0001;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // per-channel storage, limit compare and alarm status
  // halved supply channels are plain channels here; scaling is software's
  logic [NUM_CH-1:0] hiEx, loEx;
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    logic hit, bankWr, stWr;
    assign hit = convDone && chQ == CH_W'(g);
    assign bankWr = commit && bankQ == 8'(g);
    assign stWr = commit && regIdx == (g < 8 ? voltage_monitor_pkg::EVT_STAT0
                                             : voltage_monitor_pkg::EVT_STAT1);
    assign hiEx[g] = hit && cfgQ[g][voltage_monitor_pkg::CFG_ALARM_BIT]
                   && adcResult > hiQ[g];
    assign loEx[g] = hit && cfgQ[g][voltage_monitor_pkg::CFG_ALARM_BIT]
                   && adcResult < loQ[g];

    // config/status: set wins over a same-cycle write-one clear
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cfgQ[g] <= 8'h00;
      end else begin
        if (bankWr && regIdx == voltage_monitor_pkg::CH_CFG) begin
          cfgQ[g][voltage_monitor_pkg::CFG_EN_BIT] <= pwdata[0];
          cfgQ[g][voltage_monitor_pkg::CFG_ALARM_BIT] <= pwdata[4];
        end
        cfgQ[g][voltage_monitor_pkg::CFG_HIGH_BIT] <= hiEx[g] |
          (cfgQ[g][voltage_monitor_pkg::CFG_HIGH_BIT]
          & ~(bankWr && regIdx == voltage_monitor_pkg::CH_CFG
          && pwdata[1]));
        cfgQ[g][voltage_monitor_pkg::CFG_LOW_BIT] <= loEx[g] |
          (cfgQ[g][voltage_monitor_pkg::CFG_LOW_BIT]
          & ~(bankWr && regIdx == voltage_monitor_pkg::CH_CFG
          && pwdata[2]));
        cfgQ[g][voltage_monitor_pkg::CFG_DONE_BIT] <= hit |
          (cfgQ[g][voltage_monitor_pkg::CFG_DONE_BIT]
          & ~(bankWr && regIdx == voltage_monitor_pkg::CH_CFG
          && pwdata[7]));
      end
    end

    // result and limits
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        resQ[g] <= 8'h00;
        hiQ[g] <= voltage_monitor_pkg::HIGH_RST;
        loQ[g] <= voltage_monitor_pkg::LOW_RST;
      end else begin
        if (hit) begin
          resQ[g] <= adcResult;
        end
        if (bankWr && regIdx == voltage_monitor_pkg::CH_HIGH) begin
          hiQ[g] <= pwdata[7:0];
        end
        if (bankWr && regIdx == voltage_monitor_pkg::CH_LOW) begin
          loQ[g] <= pwdata[7:0];
        end
      end
    end

    // alarm status, write one to clear, set wins
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        evtStatQ[g] <= 1'b0;
      end else begin
        evtStatQ[g] <= hiEx[g] | loEx[g] |
          (evtStatQ[g] & ~(stWr && wrPlaced[g]));
      end
    end
  end

  // ==========================================================
  // interrupt outputs
  assign smiN = ~|(evtStatQ & smiEnQ);
  assign irq = |(evtStatQ & irqEnQ);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_conv_hit;
    convDone ##1 1'b1;
  endsequence
  sequence s_activate;
    commit && regIdx == portBase + 8'h01 && idxQ == voltage_monitor_pkg::IDX_ACTIVATE
      && ldnQ == voltage_monitor_pkg::LDN_MONITOR && pwdata[0];
  endsequence

  property p_start_enabled;
    adcStart |-> chEnabled && !powerLossSleep;
  endproperty
  a_start_enabled: assert property (p_start_enabled) else $error("start on bad channel");
  property p_sleep_stops;
    powerLossSleep |-> !adcStart && !convDone;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) else $error("conversion in sleep");
  property p_result_store;
    convDone |=> resQ[chQ] == $past(adcResult);
  endproperty
  a_result_store: assert property (p_result_store) else $error("result not stored");
  property p_high_flag;
    (convDone && cfgQ[chQ][voltage_monitor_pkg::CFG_ALARM_BIT] && adcResult > hiQ[chQ])
      |-> s_conv_hit ##0 cfgQ[chQ][voltage_monitor_pkg::CFG_HIGH_BIT];
  endproperty
  a_high_flag: assert property (p_high_flag) else $error("high flag missed");
  property p_sticky;
    cfgQ[0][voltage_monitor_pkg::CFG_LOW_BIT] && !(commit && bankQ == 8'h00)
      |=> cfgQ[0][voltage_monitor_pkg::CFG_LOW_BIT];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");
  property p_alarm;
    (convDone && loEx[chQ]) |=> evtStatQ[chQ] && cfgQ[chQ][voltage_monitor_pkg::CFG_LOW_BIT];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not set");
  property p_smi;
    (evtStatQ[0] && smiEnQ[0]) |-> !smiN;
  endproperty
  a_smi: assert property (p_smi) else $error("smi not asserted");
  property p_irq;
    $rose(irq) |-> $rose(|(evtStatQ & irqEnQ));
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
  property p_activate;
    s_activate |=> activeQ;
  endproperty
  a_activate: assert property (p_activate) else $error("not activated");
  property p_answer;
    psel && penable && !ackQ |=> pready;
  endproperty
  a_answer: assert property (p_answer) else $error("apb answer late");
endmodule // voltage_level_monitor
`default_nettype wire

// >>> dv/adc_model.sv
// behavioural converter core answering the monitor's start pulses
`default_nettype none
module adc_model (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // converter handshake
  input wire logic adcStart,
  input wire logic [3:0] adcChannel,
  output logic adcDone,
  output logic [7:0] adcResult
);
  timeunit 1ns;
  timeprecision 1ns;
  // per-channel analog level, set by the bench
  logic [7:0] value [16];
  int doneCnt [16];
  int startCnt;
  logic [15:0] startedMask;
  int waitQ;
  logic busyQ;
  logic slowQ;
  logic [3:0] chQ;
  // alternate prompt and slow answers; result bus toggles while idle, holds while busy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adcDone <= 1'b0;
      adcResult <= 8'h00;
      busyQ <= 1'b0;
      slowQ <= 1'b0;
      chQ <= 4'h0;
      waitQ <= 0;
      startCnt <= 0;
      startedMask <= 16'h0000;
      for (int i = 0; i < 16; i++) begin
        doneCnt[i] <= 0;
      end
    end else begin
      adcDone <= 1'b0;
      if (adcStart) begin
        busyQ <= 1'b1;
        chQ <= adcChannel;
        waitQ <= slowQ ? 6 : 1;
        slowQ <= !slowQ;
        startCnt <= startCnt + 1;
        startedMask[adcChannel] <= 1'b1;
      end else if (busyQ && waitQ > 1) begin
        waitQ <= waitQ - 1;
      end else if (busyQ) begin
        busyQ <= 1'b0;
        adcDone <= 1'b1;
        adcResult <= value[chQ];
        doneCnt[chQ] <= doneCnt[chQ] + 1;
      end else begin
        adcResult <= ~adcResult; // never hold a stale value
      end
    end
  end
endmodule // adc_model
`default_nettype wire

// >>> dv/tb_voltage_level_monitor.sv
// testbench of the scanning voltage monitor: port, scan, alarms, sleep
`default_nettype none
module tb_voltage_level_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // signals
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic configPortSelectStrap, powerLossSleep, adcStart, adcDone, smiN, irq;
  logic [3:0] adcChannel;
  logic [7:0] adcResult;
  int fails, compares, snap;
  // ==========================================================
  // instances: short settle step keeps scans quick
  voltage_level_monitor #(.SETTLE_STEP_CYCLES(2)) i_voltage_level_monitor (
    .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .configPortSelectStrap(configPortSelectStrap), .powerLossSleep(powerLossSleep),
    .adcStart(adcStart), .adcChannel(adcChannel), .adcDone(adcDone),
    .adcResult(adcResult), .smiN(smiN), .irq(irq));
  adc_model i_adc_model (.clk(clk), .arst_n(arst_n), .adcStart(adcStart),
    .adcChannel(adcChannel), .adcDone(adcDone), .adcResult(adcResult));
  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog against a hung handshake or scan
  initial begin
    #500000;
    fails++;
    close_out();
  end
  // ==========================================================
  // helpers
  task automatic close_out();
    $display("counts: compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    // request holds until a rising edge sees pready; data taken there too
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
    chk({31'h0, er}, 32'h0);
  endtask
  // pins are looked at mid-cycle, away from the flop updates
  task automatic pins(input logic s, input logic i);
    @(negedge clk);
    chk({31'h0, smiN}, {31'h0, s});
    chk({31'h0, irq}, {31'h0, i});
  endtask
  // wait for the next finished conversion of one channel, then its store
  task automatic waitConv(input int ch);
    int c, n;
    c = i_adc_model.doneCnt[ch];
    n = 0;
    while (i_adc_model.doneCnt[ch] == c && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) fails++;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_port();
    apb(1'b1, voltage_monitor_pkg::PORT_BASE0, 8'h07);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, voltage_monitor_pkg::MON_CFG, 8'h00);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    wr(voltage_monitor_pkg::PORT_BASE1, voltage_monitor_pkg::IDX_LDN);
    wr(voltage_monitor_pkg::PORT_BASE1 + 8'h01, voltage_monitor_pkg::LDN_MONITOR);
    wr(voltage_monitor_pkg::PORT_BASE1, voltage_monitor_pkg::IDX_ACTIVATE);
    wr(voltage_monitor_pkg::PORT_BASE1 + 8'h01, 8'h01);
    rdc(voltage_monitor_pkg::PORT_BASE1, voltage_monitor_pkg::IDX_ACTIVATE);
    rdc(voltage_monitor_pkg::PORT_BASE1 + 8'h01, 8'h01);
    rdc(voltage_monitor_pkg::MON_CFG, voltage_monitor_pkg::MON_CFG_RST);
    rdc(voltage_monitor_pkg::BANK_SEL, voltage_monitor_pkg::BANK_RST);
    rdc(voltage_monitor_pkg::CH_HIGH, voltage_monitor_pkg::HIGH_RST);
    rdc(voltage_monitor_pkg::CH_LOW, voltage_monitor_pkg::LOW_RST);
    rdc(voltage_monitor_pkg::EVT_STAT1, 8'h00);
    // upper pair holds channels 8 to 10 only, in its low three bits
    wr(voltage_monitor_pkg::SMI_EN1, 8'hff);
    rdc(voltage_monitor_pkg::SMI_EN1, 8'h07);
    wr(voltage_monitor_pkg::SMI_EN1, 8'h00);
    wr(voltage_monitor_pkg::IRQ_EN1, 8'hff);
    rdc(voltage_monitor_pkg::IRQ_EN1, 8'h07);
    wr(voltage_monitor_pkg::IRQ_EN1, 8'h00);
    apb(1'b0, 8'h06, 8'h00);
    chk({31'h0, er}, 32'h1);
    pins(1'b1, 1'b0);
    $display("test port and reset values done");
  endtask
  task automatic t_scan();
    i_adc_model.value[0] = 8'hb0;
    i_adc_model.value[7] = 8'h80;
    wr(voltage_monitor_pkg::BANK_SEL, 8'h07);
    wr(voltage_monitor_pkg::CH_CFG, 8'h01);
    wr(voltage_monitor_pkg::CH_HIGH, 8'h10);
    wr(voltage_monitor_pkg::BANK_SEL, 8'h00);
    wr(voltage_monitor_pkg::CH_CFG, 8'h11);
    wr(voltage_monitor_pkg::CH_HIGH, 8'haa);
    wr(voltage_monitor_pkg::CH_LOW, 8'ha0);
    wr(voltage_monitor_pkg::SMI_EN0, 8'h01);
    wr(voltage_monitor_pkg::IRQ_EN0, 8'h01);
    wr(voltage_monitor_pkg::MON_CFG, 8'h00);
    waitConv(0);
    rdc(voltage_monitor_pkg::CH_RESULT, 8'hb0);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h93);
    rdc(voltage_monitor_pkg::EVT_STAT0, 8'h01);
    pins(1'b0, 1'b1);
    waitConv(7);
    chk({16'h0, i_adc_model.startedMask}, 32'h0081);
    wr(voltage_monitor_pkg::BANK_SEL, 8'h07);
    rdc(voltage_monitor_pkg::CH_RESULT, 8'h80);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h81);
    wr(voltage_monitor_pkg::BANK_SEL, 8'h00);
    $display("test scan done");
  endtask
  task automatic t_sticky();
    i_adc_model.value[0] = 8'ha5;
    waitConv(0);
    rdc(voltage_monitor_pkg::CH_RESULT, 8'ha5);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h93);
    wr(voltage_monitor_pkg::CH_CFG, 8'h13);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h91);
    wr(voltage_monitor_pkg::EVT_STAT0, 8'h01);
    rdc(voltage_monitor_pkg::EVT_STAT0, 8'h00);
    pins(1'b1, 1'b0);
    i_adc_model.value[0] = 8'h90;
    waitConv(0);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h95);
    pins(1'b0, 1'b1);
    wr(voltage_monitor_pkg::IRQ_EN0, 8'h00);
    pins(1'b0, 1'b0);
    $display("test sticky flags and masks done");
  endtask
  task automatic t_sleep();
    @(posedge clk);
    powerLossSleep <= 1'b1;
    repeat (10) @(posedge clk);
    snap = i_adc_model.startCnt;
    repeat (300) @(posedge clk);
    chk(i_adc_model.startCnt - snap, 32'h0);
    powerLossSleep <= 1'b0;
    i_adc_model.value[0] = 8'hb0;
    waitConv(0);
    rdc(voltage_monitor_pkg::CH_CFG, 8'h97);
    $display("test sleep done");
  endtask
  // ==========================================================
  // main sequence: strap held high so the second port pair decodes
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    configPortSelectStrap = 1'b1;
    powerLossSleep = 1'b0;
    for (int i = 0; i < 16; i++) begin
      i_adc_model.value[i] = 8'h40;
    end
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_port();
    t_scan();
    t_sticky();
    t_sleep();
    close_out();
  end
endmodule // tb_voltage_level_monitor
`default_nettype wire
